// >>> shared/sfs_params.svh
// Constants for the seek and feature-select command logic.
// Assumes inclusion by the package and design files only.
`ifndef SFS_PARAMS_SVH
`define SFS_PARAMS_SVH
// Task-file register offsets
`define SFS_OFS_DATA 3'h0
`define SFS_OFS_FEAT 3'h1
`define SFS_OFS_SCNT 3'h2
`define SFS_OFS_SNUM 3'h3
`define SFS_OFS_CLOW 3'h4
`define SFS_OFS_CHIGH 3'h5
`define SFS_OFS_DHEAD 3'h6
`define SFS_OFS_CMD 3'h7
// Host-local register offsets
`define SFS_OFS_HSTAT 4'h8
`define SFS_OFS_HCTRL 4'h9
// Opcodes
`define SFS_OP_SEEK_HI 4'h7
`define SFS_OP_SETFEAT 8'hEF
// Subcommands
`define SFS_SUB_8B_ON 8'h01
`define SFS_SUB_8B_OFF 8'h81
`define SFS_SUB_WC_ON 8'h02
`define SFS_SUB_WC_OFF 8'h82
`define SFS_SUB_XFER 8'h03
`define SFS_SUB_APM_ON 8'h05
`define SFS_SUB_APM_OFF 8'h85
`define SFS_SUB_EXT_ON 8'h09
`define SFS_SUB_EXT_OFF 8'h89
`define SFS_SUB_PL1_ON 8'h0A
`define SFS_SUB_PL1_OFF 8'h8A
`define SFS_SUB_ECC_VS 8'h44
`define SFS_SUB_ECC_4 8'hBB
`define SFS_SUB_RLA_OFF 8'h55
`define SFS_SUB_RLA_ON 8'hAA
`define SFS_SUB_KEEP 8'h66
`define SFS_SUB_RESTORE 8'hCC
`define SFS_SUB_NOP_A 8'h69
`define SFS_SUB_NOP_B 8'h96
`define SFS_SUB_NOP_C 8'h97
`define SFS_SUB_CURCAP 8'h9A
// Transfer types, sector-count bits 7:3
`define SFS_XT_PIO_DEF 5'h00
`define SFS_XT_PIO_FC 5'h01
`define SFS_XT_MDMA 5'h04
// Status, error and device/head bit positions
`define SFS_ST_BSY 7
`define SFS_ST_RDY 6
`define SFS_ST_DSC 4
`define SFS_ST_ERR 0
`define SFS_ER_IDNF 4
`define SFS_ER_ABRT 2
`define SFS_DH_LBA 6
// Power-on defaults
`define SFS_DEF_WC 1'h1
`define SFS_DEF_RLA 1'h1
`define SFS_DEF_PIO 3'h0
`define SFS_DEF_DMA 3'h0
`define SFS_DEF_CURCAP 8'h00
`endif

// >>> shared/sfs_pkg.sv
// Types shared by both ends of the task-file link.
// Assumes the constants header is on the include path.
`include "sfs_params.svh"
package sfs_pkg;
  // Command sequencer; one bit changes per step except FLUSH back to IDLE
  typedef enum logic [1:0] {
    SFS_IDLE = 2'b00,
    SFS_EXEC = 2'b01,
    SFS_FLUSH = 2'b11
  } sfs_state_t;

  // Feature settings that persist between commands
  typedef struct packed {
    logic eight_bit;
    logic wcache;
    logic lookahead;
    logic apm;
    logic ext_pwr;
    logic pl1;
    logic keep_cfg;
    logic ecc4;
    logic iordy_off;
    logic [2:0] pio_mode;
    logic [2:0] dma_mode;
    logic [7:0] cur_cap;
  } sfs_cfg_t;

  // Whole device state
  typedef struct packed {
    sfs_state_t st;
    logic busy;
    logic err;
    logic intrq;
    logic flush_req;
    logic [7:0] err_reg;
    logic [7:0] feat;
    logic [7:0] scnt;
    logic [7:0] snum;
    logic [7:0] clow;
    logic [7:0] chigh;
    logic [7:0] dhead;
    logic [7:0] cmd;
    logic [7:0] rdata;
    sfs_cfg_t cfg;
  } sfs_dev_t;
endpackage : sfs_pkg

// >>> shared/sfs_tf_if.sv
// Task-file link between the host controller and the card logic.
// Both ends share one clock; no wire is two-way here.
`timescale 1ns/1ps
`default_nettype none
interface sfs_tf_if;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic intrq;
  logic wide_io_indicator;

  modport dev (
    input addr, wdata, wr, rd,
    output rdata, intrq, wide_io_indicator
  );
  modport hst (
    output addr, wdata, wr, rd,
    input rdata, intrq, wide_io_indicator
  );
endinterface : sfs_tf_if
`default_nettype wire

// >>> rtl/sfs_device.sv
// Card-side command logic for seek and feature-select.
// Assumes the task-file link runs on i_core_clk; media sizes are static.
`timescale 1ns/1ps
`default_nettype none
`include "sfs_params.svh"
module sfs_device
  import sfs_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Task-file link
  sfs_tf_if.dev tf,
  // Media geometry
  input wire logic [27:0] i_max_lba,
  input wire logic [15:0] i_cyl_count,
  input wire logic [4:0] i_head_count,
  input wire logic [7:0] i_sect_count,
  // Capabilities
  input wire logic i_dma_capable,
  input wire logic [2:0] i_max_pio,
  input wire logic [2:0] i_max_dma,
  // Cache flush handshake and soft reset
  input wire logic i_flush_done,
  input wire logic i_soft_reset,
  output logic o_flush_req,
  // Feature settings
  output logic o_eight_bit,
  output logic o_wcache,
  output logic o_lookahead,
  output logic o_apm,
  output logic o_ext_pwr,
  output logic o_pl1,
  output logic o_ecc4,
  output logic o_iordy_off,
  output logic [2:0] o_pio_mode,
  output logic [2:0] o_dma_mode,
  output logic [7:0] o_cur_cap
);

  sfs_dev_t q;
  sfs_dev_t d;

  // Power-on feature values; also what a soft reset restores
  function automatic sfs_cfg_t cfg_defaults();
    sfs_cfg_t c;
    c = '0;
    c.wcache = `SFS_DEF_WC;
    c.lookahead = `SFS_DEF_RLA;
    c.pio_mode = `SFS_DEF_PIO;
    c.dma_mode = `SFS_DEF_DMA;
    c.cur_cap = `SFS_DEF_CURCAP;
    return c;
  endfunction : cfg_defaults

  // Seek range check; true when the address is outside the media
  function automatic logic seek_out_of_range(input logic [7:0] dh, input logic [7:0] ch,
                                             input logic [7:0] cl, input logic [7:0] sn);
    logic [27:0] lba;
    logic bad;
    lba = {dh[3:0], ch, cl, sn};
    if (dh[`SFS_DH_LBA]) begin
      bad = (lba > i_max_lba);
    end else begin
      bad = ({ch, cl} >= i_cyl_count) || ({1'b0, dh[3:0]} >= i_head_count) ||
            (sn == 8'h00) || (sn > i_sect_count);
    end
    return bad;
  endfunction : seek_out_of_range

  // Status byte as the host sees it
  function automatic logic [7:0] status_byte(input sfs_dev_t s);
    logic [7:0] v;
    v = 8'h00;
    v[`SFS_ST_BSY] = s.busy;
    v[`SFS_ST_RDY] = ~s.busy;
    v[`SFS_ST_DSC] = ~s.busy;
    v[`SFS_ST_ERR] = s.err;
    return v;
  endfunction : status_byte

  // Next-state logic for the whole device
  always_comb begin
    logic [4:0] xtype;
    logic [2:0] xmode;
    logic abort;
    logic done;
    d = q;
    xtype = q.scnt[7:3];
    xmode = q.scnt[2:0];
    abort = 1'b0;
    done = 1'b0;
    d.rdata = 8'h00;

    // Register reads; a status read acknowledges the interrupt
    if (tf.rd) begin
      if (tf.addr == `SFS_OFS_FEAT) begin
        d.rdata = q.err_reg;
      end else if (tf.addr == `SFS_OFS_SCNT) begin
        d.rdata = q.scnt;
      end else if (tf.addr == `SFS_OFS_SNUM) begin
        d.rdata = q.snum;
      end else if (tf.addr == `SFS_OFS_CLOW) begin
        d.rdata = q.clow;
      end else if (tf.addr == `SFS_OFS_CHIGH) begin
        d.rdata = q.chigh;
      end else if (tf.addr == `SFS_OFS_DHEAD) begin
        d.rdata = q.dhead;
      end else if (tf.addr == `SFS_OFS_CMD) begin
        d.rdata = status_byte(q);
        d.intrq = 1'b0;
      end
    end

    // Register writes; ignored while busy so a running command sees stable inputs
    if (tf.wr && !q.busy) begin
      if (tf.addr == `SFS_OFS_FEAT) begin
        d.feat = tf.wdata;
      end else if (tf.addr == `SFS_OFS_SCNT) begin
        d.scnt = tf.wdata;
      end else if (tf.addr == `SFS_OFS_SNUM) begin
        d.snum = tf.wdata;
      end else if (tf.addr == `SFS_OFS_CLOW) begin
        d.clow = tf.wdata;
      end else if (tf.addr == `SFS_OFS_CHIGH) begin
        d.chigh = tf.wdata;
      end else if (tf.addr == `SFS_OFS_DHEAD) begin
        d.dhead = tf.wdata;
      end else if (tf.addr == `SFS_OFS_CMD) begin
        d.cmd = tf.wdata;
        d.busy = 1'b1;
        d.intrq = 1'b0;
        d.st = SFS_EXEC;
      end
    end

    // Soft reset restores defaults unless the host asked to keep them
    if (i_soft_reset && !q.cfg.keep_cfg) begin
      d.cfg = cfg_defaults();
    end

    case (q.st)
      SFS_IDLE: begin
      end
      SFS_EXEC: begin
        done = 1'b1;
        if (q.cmd[7:4] == `SFS_OP_SEEK_HI) begin
          d.err_reg = seek_out_of_range(q.dhead, q.chigh, q.clow, q.snum) ?
                      (8'h01 << `SFS_ER_IDNF) : 8'h00;
        end else if (q.cmd == `SFS_OP_SETFEAT) begin
          case (q.feat)
            `SFS_SUB_8B_ON: d.cfg.eight_bit = 1'b1;
            `SFS_SUB_8B_OFF: d.cfg.eight_bit = 1'b0;
            `SFS_SUB_WC_ON: d.cfg.wcache = 1'b1;
            `SFS_SUB_WC_OFF: begin
              d.cfg.wcache = 1'b0;
              if (q.cfg.wcache) begin
                done = 1'b0;
                d.flush_req = 1'b1;
                d.st = SFS_FLUSH;
              end
            end
            `SFS_SUB_XFER: begin
              if (xtype == `SFS_XT_PIO_DEF && xmode == 3'h0) begin
                d.cfg.pio_mode = 3'h0;
                d.cfg.iordy_off = 1'b0;
              end else if (xtype == `SFS_XT_PIO_DEF && xmode == 3'h1) begin
                d.cfg.pio_mode = 3'h0;
                d.cfg.iordy_off = 1'b1;
              end else if (xtype == `SFS_XT_PIO_FC && xmode <= i_max_pio) begin
                d.cfg.pio_mode = xmode;
                d.cfg.iordy_off = 1'b0;
              end else if (xtype == `SFS_XT_MDMA && i_dma_capable && xmode <= i_max_dma) begin
                d.cfg.dma_mode = xmode;
              end else begin
                abort = 1'b1;
              end
            end
            `SFS_SUB_APM_ON: d.cfg.apm = 1'b1;
            `SFS_SUB_APM_OFF: d.cfg.apm = 1'b0;
            `SFS_SUB_EXT_ON: d.cfg.ext_pwr = 1'b1;
            `SFS_SUB_EXT_OFF: d.cfg.ext_pwr = 1'b0;
            `SFS_SUB_PL1_ON: d.cfg.pl1 = 1'b1;
            `SFS_SUB_PL1_OFF: d.cfg.pl1 = 1'b0;
            `SFS_SUB_ECC_VS: d.cfg.ecc4 = 1'b0;
            `SFS_SUB_ECC_4: d.cfg.ecc4 = 1'b1;
            `SFS_SUB_RLA_ON: d.cfg.lookahead = 1'b1;
            `SFS_SUB_RLA_OFF: d.cfg.lookahead = 1'b0;
            `SFS_SUB_KEEP: d.cfg.keep_cfg = 1'b1;
            `SFS_SUB_RESTORE: d.cfg.keep_cfg = 1'b0;
            `SFS_SUB_NOP_A, `SFS_SUB_NOP_B, `SFS_SUB_NOP_C: begin
            end
            `SFS_SUB_CURCAP: d.cfg.cur_cap = q.scnt;
            default: abort = 1'b1;
          endcase
          d.err_reg = abort ? (8'h01 << `SFS_ER_ABRT) : 8'h00;
        end else begin
          // Opcodes this block does not own are refused
          d.err_reg = 8'h01 << `SFS_ER_ABRT;
        end
        if (done) begin
          d.st = SFS_IDLE;
        end
      end
      SFS_FLUSH: begin
        // Completion waits until the cache is safely in flash
        if (i_flush_done) begin
          d.flush_req = 1'b0;
          d.err_reg = 8'h00;
          d.st = SFS_IDLE;
          done = 1'b1;
        end
      end
      default: d.st = SFS_IDLE;
    endcase

    // Completion: drop busy, post error, raise interrupt (set wins over read)
    if (done) begin
      d.busy = 1'b0;
      d.err = (d.err_reg != 8'h00);
      d.intrq = 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '{st: SFS_IDLE, cfg: cfg_defaults(), default: '0};
    end else begin
      q <= d;
    end
  end

  // Link outputs; data-register access is narrow in 8-bit mode
  assign tf.rdata = q.rdata;
  assign tf.intrq = q.intrq;
  assign tf.wide_io_indicator = (tf.rd || tf.wr) && (tf.addr == `SFS_OFS_DATA) &&
                                !q.cfg.eight_bit;

  // Settings to the rest of the card
  assign o_flush_req = q.flush_req;
  assign o_eight_bit = q.cfg.eight_bit;
  assign o_wcache = q.cfg.wcache;
  assign o_lookahead = q.cfg.lookahead;
  assign o_apm = q.cfg.apm;
  assign o_ext_pwr = q.cfg.ext_pwr;
  assign o_pl1 = q.cfg.pl1;
  assign o_ecc4 = q.cfg.ecc4;
  assign o_iordy_off = q.cfg.iordy_off;
  assign o_pio_mode = q.cfg.pio_mode;
  assign o_dma_mode = q.cfg.dma_mode;
  assign o_cur_cap = q.cfg.cur_cap;

endmodule : sfs_device
`default_nettype wire

// >>> rtl/sfs_host.sv
// Host controller end: forwards software accesses onto the task-file link.
// Assumes software uses the plain strobe port on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sfs_params.svh"
module sfs_host
  import sfs_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Software port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Task-file link
  sfs_tf_if.hst tf
);

  // Host state kept as one struct
  typedef struct packed {
    logic dma_use;
    logic refused;
    logic local_sel;
    logic [7:0] feat;
    logic [7:0] rdata;
  } sfs_host_state_t;

  sfs_host_state_t q;
  sfs_host_state_t d;
  logic link_sel;
  logic bad_8bit;

  // Addresses 0..7 are the card's task file, above that host registers
  assign link_sel = (i_addr[3] == 1'b0);
  // 8-bit mode must never be asked for while DMA is in use
  assign bad_8bit = i_wr && link_sel && (i_addr[2:0] == `SFS_OFS_CMD) &&
                    (i_wdata == `SFS_OP_SETFEAT) && (q.feat == `SFS_SUB_8B_ON) &&
                    q.dma_use;

  // Strobes pass straight through so the card answers in the next cycle
  assign tf.addr = i_addr[2:0];
  assign tf.wdata = i_wdata;
  assign tf.wr = i_wr && link_sel && !bad_8bit;
  assign tf.rd = i_rd && link_sel;

  // Next-state logic
  always_comb begin
    d = q;
    d.rdata = 8'h00;
    d.local_sel = i_rd && !link_sel;
    if (i_wr && link_sel && (i_addr[2:0] == `SFS_OFS_FEAT)) begin
      d.feat = i_wdata;
    end
    if (i_rd) begin
      if (i_addr == `SFS_OFS_HSTAT) begin
        d.rdata = {5'h00, tf.wide_io_indicator, q.refused, tf.intrq};
        d.refused = 1'b0;
      end else if (i_addr == `SFS_OFS_HCTRL) begin
        d.rdata = {7'h00, q.dma_use};
      end
    end
    if (i_wr && (i_addr == `SFS_OFS_HCTRL)) begin
      d.dma_use = i_wdata[0];
    end
    // A refusal in the cycle of the clearing read still sticks
    if (bad_8bit) begin
      d.refused = 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Read data: local register or the card's registered answer
  assign o_rdata = q.local_sel ? q.rdata : tf.rdata;

endmodule : sfs_host
`default_nettype wire

// >>> testbench/sfs_link_assertions.sv
// Checker for the task-file link between the host and card ends.
// Assumes it sits beside the link on the shared core clock.
`timescale 1ns/1ps
`default_nettype none
module sfs_link_assertions (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // Link signals
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic intrq,
  input wire logic wide_io_indicator
);
  logic cmd;
  logic pend_q;
  logic eight_q;
  logic [7:0] feat_q;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  assign cmd = wr && addr == 3'h7;
  // Wire-side mirror of 8-bit mode; blind to soft reset, so keep it off then
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_q <= 1'b0;
      eight_q <= 1'b0;
      feat_q <= 8'h00;
    end else begin
      pend_q <= cmd || (pend_q && !intrq);
      if (wr && addr == 3'h1) feat_q <= wdata;
      if (cmd && wdata == 8'hEF && feat_q == 8'h01) eight_q <= 1'b1;
      if (cmd && wdata == 8'hEF && feat_q == 8'h81) eight_q <= 1'b0;
    end
  end
  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_cmd_drops_irq: assert property (cmd |=> !intrq)
    else $error("interrupt kept after command write");
  a_done_bound: assert property (cmd |-> ##[2:40] intrq)
    else $error("command did not complete in time");
  a_rise_has_cmd: assert property ($rose(intrq) |-> pend_q)
    else $error("interrupt without a command");
  a_irq_holds: assert property (intrq && !(rd && addr == 3'h7) && !cmd |=> intrq)
    else $error("interrupt dropped on its own");
  // While the interrupt stands no command is running, so a status read always clears it
  a_read_clears: assert property (intrq && rd && addr == 3'h7 && !cmd |=> !intrq)
    else $error("status read left interrupt set");
  a_status_bits: assert property ($past(rd) && $past(addr) == 3'h7 |->
    rdata[6] == !rdata[7] && rdata[4] == !rdata[7])
    else $error("ready bits disagree with busy");
  a_wide_mode: assert property ((rd || wr) && addr == 3'h0 |->
    wide_io_indicator == !eight_q)
    else $error("wide indicator wrong for mode");
  a_wide_only: assert property (wide_io_indicator |-> (rd || wr) && addr == 3'h0)
    else $error("wide indicator outside data access");
  c_feat: cover property (cmd && wdata == 8'hEF);
  c_done: cover property ($rose(intrq));
  c_wide: cover property (wide_io_indicator);
endmodule : sfs_link_assertions
`default_nettype wire

// >>> testbench/seek_and_feature_select_tb.sv
// Bench: host and card ends joined by the task-file link.
// Assumes one 25 MHz clock; software reaches the card via the host port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module seek_and_feature_select_tb;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [3:0] sa = 4'h0;
  logic [7:0] sd = 8'h00;
  logic swr = 1'b0;
  logic srd = 1'b0;
  logic [7:0] srdata;
  logic fdone = 1'b0;
  logic srst = 1'b0;
  logic freq;
  logic iordy;
  logic [6:0] cf;
  logic [2:0] pio;
  logic [2:0] dma;
  logic [7:0] cap;
  logic [27:0] mlba = 28'h00000FF;
  logic [15:0] ncyl = 16'h0010;
  logic [4:0] nhd = 5'h04;
  logic [7:0] nsec = 8'h10;
  logic dmac = 1'b1;
  logic [2:0] mpio = 3'h4;
  logic [2:0] mdma = 3'h2;
  int error_cnt = 0;
  int check_count = 0;
  sfs_tf_if tf ();
  sfs_host i_sfs_host (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(sa),
    .i_wdata(sd), .i_wr(swr), .i_rd(srd), .o_rdata(srdata), .tf(tf.hst));
  sfs_device i_sfs_device (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .tf(tf.dev),
    .i_max_lba(mlba), .i_cyl_count(ncyl), .i_head_count(nhd), .i_sect_count(nsec),
    .i_dma_capable(dmac), .i_max_pio(mpio), .i_max_dma(mdma), .i_flush_done(fdone),
    .i_soft_reset(srst), .o_flush_req(freq), .o_eight_bit(cf[6]), .o_wcache(cf[5]),
    .o_lookahead(cf[4]), .o_apm(cf[3]), .o_ext_pwr(cf[2]), .o_pl1(cf[1]),
    .o_ecc4(cf[0]), .o_iordy_off(iordy), .o_pio_mode(pio), .o_dma_mode(dma),
    .o_cur_cap(cap));
  sfs_link_assertions i_sfs_link_assertions (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .addr(tf.addr), .wdata(tf.wdata), .wr(tf.wr), .rd(tf.rd), .rdata(tf.rdata),
    .intrq(tf.intrq), .wide_io_indicator(tf.wide_io_indicator));
  // Free-running core clock, 40 ns period
  always #20 i_core_clk = ~i_core_clk;
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    sa <= a;
    sd <= d;
    swr <= 1'b1;
    @(posedge i_core_clk);
    swr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe, so sample just then
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    sa <= a;
    srd <= 1'b1;
    @(posedge i_core_clk);
    srd <= 1'b0;
    #1 d = srdata;
  endtask : rd_reg
  task automatic issue(input logic [7:0] f, c, dh, ch, cl, sn, op);
    wr_reg(4'h1, f);
    wr_reg(4'h2, c);
    wr_reg(4'h3, sn);
    wr_reg(4'h4, cl);
    wr_reg(4'h5, ch);
    wr_reg(4'h6, dh);
    wr_reg(4'h7, op);
  endtask : issue
  // Poll busy under a bound, then judge status and error register
  task automatic finish(input logic [7:0] e);
    logic [7:0] s;
    int n;
    s = 8'h80;
    n = 0;
    while (s[7] && n < 50) begin
      rd_reg(4'h7, s);
      n++;
    end
    `CHK("status", {7'h28, e != 8'h00}, s)
    rd_reg(4'h1, s);
    `CHK("error", e, s)
  endtask : finish
  task automatic feat(input logic [7:0] f, c, e);
    issue(f, c, 8'hA0, 8'h00, 8'h00, 8'h00, 8'hEF);
    finish(e);
  endtask : feat
  task automatic t_toggle;
    logic [7:0] sub [19] = '{8'h01, 8'h81, 8'h05, 8'h85, 8'h09, 8'h89, 8'h0A,
      8'h8A, 8'h55, 8'hAA, 8'hBB, 8'h44, 8'h69, 8'h96, 8'h97, 8'h66, 8'hCC,
      8'h00, 8'h77};
    logic [6:0] x [19] = '{7'h70, 7'h30, 7'h38, 7'h30, 7'h34, 7'h30, 7'h32,
      7'h30, 7'h20, 7'h30, 7'h31, 7'h30, 7'h30, 7'h30, 7'h30, 7'h30, 7'h30,
      7'h30, 7'h30};
    logic [7:0] d;
    `CHK("defaults", 7'h30, cf)
    for (int i = 0; i < 19; i++) begin
      feat(sub[i], 8'h00, (i > 16) ? 8'h04 : 8'h00);
      rd_reg(4'h0, d);
      `CHK("config", x[i], cf)
    end
    feat(8'h9A, 8'h5A, 8'h00);
    `CHK("current", 8'h5A, cap)
    $display("toggle test done");
  endtask : t_toggle
  task automatic t_xfer;
    logic [7:0] c [12] = '{8'h01, 8'h00, 8'h0C, 8'h02, 8'h10, 8'h40, 8'h80,
      8'h22, 8'h21, 8'h20, 8'h23, 8'h0D};
    logic [6:0] x [12] = '{7'h40, 7'h00, 7'h20, 7'h20, 7'h20, 7'h20, 7'h20,
      7'h22, 7'h21, 7'h20, 7'h20, 7'h20};
    for (int i = 0; i < 12; i++) begin
      feat(8'h03, c[i], ((i > 2 && i < 7) || i > 9) ? 8'h04 : 8'h00);
      `CHK("modes", x[i], {iordy, pio, dma})
    end
    // A card without DMA must refuse multiword DMA; mode 1 is the one tried here
    @(posedge i_core_clk);
    dmac <= 1'b0;
    feat(8'h03, 8'h21, 8'h04);
    `CHK("no dma", 7'h20, {iordy, pio, dma})
    @(posedge i_core_clk);
    dmac <= 1'b1;
    $display("transfer mode test done");
  endtask : t_xfer
  // Hold the flush back a while to see busy stand until it ends
  task automatic t_flush;
    logic [7:0] s;
    int n;
    issue(8'h82, 8'h00, 8'hA0, 8'h00, 8'h00, 8'h00, 8'hEF);
    n = 0;
    while (!freq && n < 20) begin
      @(posedge i_core_clk);
      n++;
    end
    rd_reg(4'h7, s);
    `CHK("flush busy", 2'b11, {freq, s[7]})
    @(posedge i_core_clk);
    fdone <= 1'b1;
    finish(8'h00);
    @(posedge i_core_clk);
    fdone <= 1'b0;
    `CHK("cache off", 2'b00, {freq, cf[5]})
    // Disabling an already idle cache has nothing to flush
    feat(8'h82, 8'h00, 8'h00);
    `CHK("no flush", 2'b00, {freq, cf[5]})
    feat(8'h02, 8'h00, 8'h00);
    `CHK("cache on", 1'b1, cf[5])
    $display("flush test done");
  endtask : t_flush
  task automatic t_seek;
    logic [47:0] t [10] = '{48'h70A1000F0100, 48'h7FA400000110, 48'h75A000100110,
      48'h70A000000010, 48'h70A000001000, 48'h70A000001110, 48'h70E00000FF00,
      48'h70E000010010, 48'h70E100000010, 48'h20A000000104};
    for (int i = 0; i < 10; i++) begin
      issue(8'hCC, 8'h55, t[i][39:32], t[i][31:24], t[i][23:16], t[i][15:8],
        t[i][47:40]);
      finish(t[i][7:0]);
    end
    $display("seek test done");
  endtask : t_seek
  task automatic t_refuse;
    logic [7:0] s;
    // Interrupt must stand untouched until software reads the card status
    issue(8'h69, 8'h00, 8'hA0, 8'h00, 8'h00, 8'h00, 8'hEF);
    repeat (4) @(posedge i_core_clk);
    rd_reg(4'h8, s);
    `CHK("irq pending", 2'b01, s[1:0])
    finish(8'h00);
    wr_reg(4'h9, 8'h01);
    issue(8'h01, 8'h00, 8'hA0, 8'h00, 8'h00, 8'h00, 8'hEF);
    rd_reg(4'h8, s);
    `CHK("refused", 2'b10, s[1:0])
    rd_reg(4'h8, s);
    `CHK("refused clear", 2'b00, {s[1], cf[6]})
    wr_reg(4'h9, 8'h00);
    $display("refuse test done");
  endtask : t_refuse
  task automatic soft_rst(input logic e);
    @(posedge i_core_clk);
    srst <= 1'b1;
    @(posedge i_core_clk);
    srst <= 1'b0;
    @(posedge i_core_clk);
    `CHK("power mgmt", e, cf[3])
  endtask : soft_rst
  task automatic t_soft;
    feat(8'h05, 8'h00, 8'h00);
    soft_rst(1'b0);
    feat(8'h66, 8'h00, 8'h00);
    feat(8'h05, 8'h00, 8'h00);
    soft_rst(1'b1);
    feat(8'hCC, 8'h00, 8'h00);
    soft_rst(1'b0);
    $display("soft reset test done");
  endtask : t_soft
  // Whole run is about a thousand cycles; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge i_core_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    t_toggle();
    t_xfer();
    t_flush();
    t_seek();
    t_refuse();
    t_soft();
    test_done();
  end
endmodule : seek_and_feature_select_tb
`default_nettype wire
